// *** core/fpmc_pkg.sv ***
// shared constants for the fp pipeline mode control link and both ends
package fpmc_pkg;
    localparam int MODE_W  = 16;
    localparam int FUNC_W  = 7;
    localparam int STAT_W  = 4;
    localparam int EXC_N   = 11;
    localparam int TMR_W   = 4;
    localparam int NIB_W   = 4;
    localparam int NSEL_W  = 2;
    // mode word bit positions
    localparam int MB_DENORM = 0;
    localparam int MB_BIT1   = 1;  // mul pipe 1 enable, alu fix rounding
    localparam int MB_RND    = 2;  // two bits
    localparam int MB_RES_EN = 4;
    localparam int MB_BIT5   = 5;  // mul pipe 2 enable, alu pipes 3/4 enable
    localparam int MB_BIT6   = 6;  // mul stage 2 field low, alu pipe 2 enable
    localparam int MB_BIT7   = 7;  // mul stage 2 field high, alu pipe 1 enable
    localparam int MB_PAC    = 8;  // two bits
    localparam int MB_COMPAT = 11; // two bits
    localparam int MB_LEGACY = 12;
    localparam int MB_ADVSEL = 13;
    localparam logic [MODE_W-1:0] MODE_RST = 16'h0000;
    // function code fields
    localparam int FB_NSEL = 4;
    localparam logic [FUNC_W-1:0] FIX_FN_LO = 7'h40;
    localparam logic [FUNC_W-1:0] FIX_FN_HI = 7'h4D;
    localparam logic [2:0] CMP_FN_TOP  = 3'h2;
    localparam logic [1:0] CMP_FN_NONE = 2'h3;
    localparam logic [2:0] FIX_ST_ZERO = 3'h0;
    localparam logic [2:0] FIX_ST_FIN  = 3'h2;
    localparam logic [2:0] FIX_ST_OVF  = 3'h5;
    localparam logic [STAT_W-1:0] STAT_NONE = 4'h0;
    localparam logic [TMR_W-1:0]  TMR_ONE   = 4'h1;
    // host register map
    localparam int APB_AW = 8;
    localparam logic [APB_AW-1:0] A_CMD    = 8'h00;
    localparam logic [APB_AW-1:0] A_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] A_PRESET = 8'h08;
    localparam logic [APB_AW-1:0] A_MIRROR = 8'h0C;
    localparam int CB_UNIT = 7;
    localparam int CB_DBL  = 8;
    localparam int CB_LOAD = 9;
    localparam int SB_PEND = 0;
    localparam int SB_STAT = 4;
    localparam int SB_DONE = 8;
    // preset mode words: slow mul, fast mul, fast alu, slow alu
    localparam logic [MODE_W-1:0] PRE_MUL_SLOW = 16'h2132;
    localparam logic [MODE_W-1:0] PRE_MUL_FAST = 16'h0032;
    localparam logic [MODE_W-1:0] PRE_ALU_FAST = 16'h00D0;
    localparam logic [MODE_W-1:0] PRE_ALU_SLOW = 16'h01D0;
    localparam logic [NSEL_W-1:0] NIB_LAST = 2'h3;
endpackage : fpmc_pkg

// *** core/fpmc_link_if.sv ***
// link between the host sequencer end and the pipeline control end
`timescale 1ns/1ps
interface fpmc_link_if;
    logic                          req;
    logic                          req_load;
    logic                          req_unit;
    logic                          req_dbl;
    logic [fpmc_pkg::FUNC_W-1:0]   req_func;
    logic                          busy;
    logic                          stat_valid;
    logic [fpmc_pkg::STAT_W-1:0]   stat;

    modport dev_mp (
        input  req, req_load, req_unit, req_dbl, req_func,
        output busy, stat_valid, stat
    );
    modport host_mp (
        output req, req_load, req_unit, req_dbl, req_func,
        input  busy, stat_valid, stat
    );
endinterface : fpmc_link_if

// *** core/fpmc_stage_timer.sv ***
// down counter that pulses a stage latch a set number of cycles after start
`timescale 1ns/1ps
module fpmc_stage_timer (
    input  wire logic                       CLK,   // system clock
    input  wire logic                       RST_N, // async reset, low
    input  wire logic                       START, // load the count
    input  wire logic [fpmc_pkg::TMR_W-1:0] LEN,   // cycles to done, at least 1
    output logic                            DONE,  // high in the last cycle
    output logic                            RUN    // counting
);
    import fpmc_pkg::*;

    logic [TMR_W-1:0] cnt;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= '0;
        end else if (START) begin
            cnt <= LEN;
        end else if (cnt != '0) begin
            cnt <= cnt - TMR_ONE;
        end
    end

    assign DONE = (cnt == TMR_ONE);
    assign RUN  = (cnt != '0);
endmodule : fpmc_stage_timer

// *** core/fpmc_dev_end.sv ***
// pipeline timing, mode words and result status of the fp multiplier and alu
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module fpmc_dev_end (
    input  wire logic                       CLK,            // system clock
    input  wire logic                       RST_N,          // async reset, low
    fpmc_link_if.dev_mp                     LINK,           // host link
    input  wire logic [fpmc_pkg::EXC_N-1:0] EXC_IN,         // raw exceptions
    input  wire logic [fpmc_pkg::STAT_W-1:0] CMP_COND,      // compare outcome
    input  wire logic                       FIX_SIGN,       // fixed result sign
    input  wire logic                       FIX_ZERO,       // fixed result zero
    input  wire logic                       FIX_OVF,        // fixed overflow
    output logic                            PIPE1_STB,      // pipe 1 latch
    output logic                            ACCUM_STB,      // accumulate latch
    output logic                            PIPE2_STB,      // pipe 2 latch
    output logic                            PIPE3_STB,      // stage 3 latch
    output logic                            RESULT_STB,     // result latch
    output logic                            PIPE1_EN,       // pipe 1 latched
    output logic                            PIPE2_EN,       // pipe 2 latched
    output logic                            PIPE34_EN,      // alu pipes 3/4
    output logic                            RESULT_EN,      // result latched
    output logic                            DENORM_FAST,    // flush denormals
    output logic [1:0]                      ROUND_MODE,     // rounding mode
    output logic                            FIX_ROUND_ZERO, // fix rounds to 0
    output logic                            HI_HALF,        // single in top half
    output logic                            LEGACY_COMMON,  // common legacy
    output logic [1:0]                      COMPAT_SEL,     // compat field
    output logic                            OP_UNIT,        // 1 alu, 0 mul
    output logic                            OP_DBL          // double op
);
    import fpmc_pkg::*;

    logic [MODE_W-1:0] mul_mode_word;
    logic [MODE_W-1:0] alu_mode_word;
    logic [MODE_W-1:0] req_word;
    logic [MODE_W-1:0] cur_word;
    logic              cur_unit;
    logic              cur_dbl;
    logic [FUNC_W-1:0] cur_func;
    logic              go;
    logic              ld;
    logic              t1_done;
    logic              t2_done;
    logic              t3_done;
    logic              t1_run;
    logic              t2_run;
    logic              t3_run;
    logic [TMR_W-1:0]  len1;
    logic [TMR_W-1:0]  len2;
    logic [TMR_W-1:0]  len3;
    logic [TMR_W-1:0]  s2_unit;
    logic              acc_q;
    logic              stat_v_q;
    logic [STAT_W-1:0] stat_q;
    logic [STAT_W-1:0] next_stat;
    logic [2:0]        fix_code;
    logic              is_cmp;
    logic              is_fix;

    // one operation in flight; loads are taken even while busy
    assign go = LINK.req && !LINK.req_load && !LINK.busy;
    assign ld = LINK.req && LINK.req_load;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mul_mode_word <= MODE_RST;
        end else if (ld && !LINK.req_unit) begin
            mul_mode_word[LINK.req_func[FB_NSEL +: NSEL_W]*NIB_W +: NIB_W]
                <= LINK.req_func[NIB_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            alu_mode_word <= MODE_RST;
        end else if (ld && LINK.req_unit) begin
            alu_mode_word[LINK.req_func[FB_NSEL +: NSEL_W]*NIB_W +: NIB_W]
                <= LINK.req_func[NIB_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur_unit <= 1'b0;
            cur_dbl  <= 1'b0;
            cur_func <= '0;
        end else if (go) begin
            cur_unit <= LINK.req_unit;
            cur_dbl  <= LINK.req_dbl;
            cur_func <= LINK.req_func;
        end
    end

    assign req_word = LINK.req_unit ? alu_mode_word : mul_mode_word;
    assign cur_word = cur_unit ? alu_mode_word : mul_mode_word;

    // stage length N+1 means clock divided by N+1
    assign len1 = TMR_W'(req_word[MB_PAC +: 2]) + TMR_ONE;
    assign len3 = TMR_W'(cur_word[MB_PAC +: 2]) + TMR_ONE;
    assign s2_unit = TMR_W'(cur_word[MB_BIT6 +: 2]) + TMR_ONE;

    // mul stage 2 from its own field and select, alu stage 2 from pipeline field
    always_comb begin
        if (cur_unit) begin
            // alu stage 2 follows pipeline field
            len2 = len3;
        end else if (cur_dbl || cur_word[MB_ADVSEL]) begin
            len2 = s2_unit << 1;
        end else begin
            len2 = s2_unit;
        end
    end

    // second stage 1 latch N+1 after start
    fpmc_stage_timer u_t1 (
        .CLK   (CLK),
        .RST_N (RST_N),
        .START (go),
        .LEN   (len1),
        .DONE  (t1_done),
        .RUN   (t1_run)
    );

    // stage 2 counted after pipe 1
    fpmc_stage_timer u_t2 (
        .CLK   (CLK),
        .RST_N (RST_N),
        .START (t1_done),
        .LEN   (len2),
        .DONE  (t2_done),
        .RUN   (t2_run)
    );

    // stage 3 of N+1, two cycles at advance 01
    fpmc_stage_timer u_t3 (
        .CLK   (CLK),
        .RST_N (RST_N),
        .START (t2_done),
        .LEN   (len3),
        .DONE  (t3_done),
        .RUN   (t3_run)
    );

    assign LINK.busy = t1_run || t2_run || t3_run;

    // accumulate latch one cycle after pipe 1
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            acc_q <= 1'b0;
        end else begin
            acc_q <= t1_done && !cur_unit;
        end
    end

    assign PIPE1_EN  = cur_unit ? cur_word[MB_BIT7] : cur_word[MB_BIT1];
    assign PIPE2_EN  = cur_unit ? cur_word[MB_BIT6] : cur_word[MB_BIT5];
    assign PIPE34_EN = cur_unit && cur_word[MB_BIT5];
    assign RESULT_EN = cur_word[MB_RES_EN];

    // disabled register stays transparent, no strobe
    assign PIPE1_STB  = (go ? req_word[LINK.req_unit ? MB_BIT7 : MB_BIT1] : 1'b0)
                        || (t1_done && PIPE1_EN);
    assign PIPE2_STB  = t2_done && PIPE2_EN;
    assign PIPE3_STB  = t3_done && (!cur_unit || PIPE34_EN);
    assign RESULT_STB = t3_done && RESULT_EN;
    assign ACCUM_STB  = acc_q;

    assign DENORM_FAST    = cur_word[MB_DENORM];
    assign ROUND_MODE     = cur_word[MB_RND +: 2];
    assign FIX_ROUND_ZERO = cur_unit && cur_word[MB_BIT1];
    // legacy select low is the common setup
    assign LEGACY_COMMON  = !mul_mode_word[MB_LEGACY];
    assign COMPAT_SEL     = mul_mode_word[MB_COMPAT +: 2];
    // single products sit in upper half
    assign HI_HALF        = !cur_unit && !cur_dbl;
    assign OP_UNIT        = cur_unit;
    assign OP_DBL         = cur_dbl;

    // index 0 is the highest priority, reported as code 1
    function automatic logic [STAT_W-1:0] exc_code(input logic [EXC_N-1:0] e);
        logic [STAT_W-1:0] c;
        c = STAT_NONE;
        for (int i = EXC_N - 1; i >= 0; i--) begin
            if (e[i]) begin
                c = STAT_W'(i + 1);
            end
        end
        return c;
    endfunction : exc_code

    assign is_cmp = cur_unit && (cur_func[6:4] == CMP_FN_TOP) && !cur_func[1]
                    && (cur_func[3:2] != CMP_FN_NONE);
    assign is_fix = cur_unit && (cur_func >= FIX_FN_LO) && (cur_func <= FIX_FN_HI);

    assign fix_code = FIX_OVF ? FIX_ST_OVF : (FIX_ZERO ? FIX_ST_ZERO : FIX_ST_FIN);

    always_comb begin
        if (is_cmp) begin
            next_stat = CMP_COND;
        end else if (is_fix) begin
            next_stat = {FIX_SIGN, fix_code};
        end else begin
            next_stat = exc_code(EXC_IN);
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stat_q <= STAT_NONE;
        end else if (t3_done) begin
            stat_q <= next_stat;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            stat_v_q <= 1'b0;
        end else begin
            stat_v_q <= t3_done;
        end
    end

    assign LINK.stat_valid = stat_v_q;
    assign LINK.stat       = stat_q;
endmodule : fpmc_dev_end

// *** core/fpmc_host_end.sv ***
// sequencer end: apb command registers driving the pipeline control link
`timescale 1ns/1ps
module fpmc_host_end (
    input  wire logic                        CLK,     // system clock
    input  wire logic                        RST_N,   // async reset, low
    input  wire logic                        PSEL,    // apb select
    input  wire logic                        PENABLE, // apb access phase
    input  wire logic                        PWRITE,  // apb write
    input  wire logic [fpmc_pkg::APB_AW-1:0] PADDR,   // apb byte address
    input  wire logic [31:0]                 PWDATA,  // apb write data
    output logic      [31:0]                 PRDATA,  // apb read data
    output logic                             PREADY,  // apb ready
    output logic                             PSLVERR, // apb error
    fpmc_link_if.host_mp                     LINK     // device link
);
    import fpmc_pkg::*;

    typedef enum logic [1:0] { H_IDLE, H_SEND, H_WAIT, H_PRESET } fpmc_hstate_t;

    fpmc_hstate_t      state;
    logic [FUNC_W-1:0] p_func;
    logic              p_unit;
    logic              p_dbl;
    logic              p_load;
    logic [1:0]        p_pre;
    logic [NSEL_W-1:0] nib;
    logic [MODE_W-1:0] pre_word;
    logic [MODE_W-1:0] mir_mul;
    logic [MODE_W-1:0] mir_alu;
    logic [STAT_W-1:0] last_stat;
    logic              done;
    logic              acc;
    logic              wr;
    logic              mapped;
    logic              refuse;
    logic              fire;

    assign acc    = PSEL && PENABLE;
    assign mapped = (PADDR == A_CMD) || (PADDR == A_STATUS)
                    || (PADDR == A_PRESET) || (PADDR == A_MIRROR);
    // a second order while one is pending is refused, not queued
    assign refuse = PWRITE && (state != H_IDLE)
                    && ((PADDR == A_CMD) || (PADDR == A_PRESET));
    assign wr      = acc && PWRITE && mapped && !refuse;
    assign PREADY  = 1'b1;
    assign PSLVERR = acc && (!mapped || refuse);

    always_comb begin
        case (p_pre)
            2'h0:    pre_word = PRE_MUL_SLOW;
            2'h1:    pre_word = PRE_MUL_FAST;
            2'h2:    pre_word = PRE_ALU_FAST;
            default: pre_word = PRE_ALU_SLOW;
        endcase
    end

    assign fire          = (state == H_SEND || state == H_PRESET) && !LINK.busy;
    assign LINK.req      = fire;
    assign LINK.req_load = (state == H_PRESET) || p_load;
    assign LINK.req_unit = (state == H_PRESET) ? p_pre[1] : p_unit;
    assign LINK.req_dbl  = p_dbl;
    // nibble select and value in the function code
    assign LINK.req_func = (state == H_PRESET)
                           ? {1'b0, nib, pre_word[nib*NIB_W +: NIB_W]} : p_func;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= H_IDLE;
            nib   <= '0;
        end else begin
            case (state)
                H_IDLE: begin
                    nib <= '0;
                    if (wr && PADDR == A_CMD) begin
                        state <= H_SEND;
                    end else if (wr && PADDR == A_PRESET) begin
                        state <= H_PRESET;
                    end
                end
                H_SEND: if (fire) begin
                    state <= p_load ? H_IDLE : H_WAIT;
                end
                H_WAIT: if (LINK.stat_valid) begin
                    state <= H_IDLE;
                end
                H_PRESET: if (fire) begin
                    nib <= nib + 2'h1;
                    if (nib == NIB_LAST) begin
                        state <= H_IDLE;
                    end
                end
                default: state <= H_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            p_func <= '0;
            p_unit <= 1'b0;
            p_dbl  <= 1'b0;
            p_load <= 1'b0;
            p_pre  <= '0;
        end else if (wr && PADDR == A_CMD) begin
            p_func <= PWDATA[FUNC_W-1:0];
            p_unit <= PWDATA[CB_UNIT];
            p_dbl  <= PWDATA[CB_DBL];
            p_load <= PWDATA[CB_LOAD];
        end else if (wr && PADDR == A_PRESET) begin
            p_pre  <= PWDATA[1:0];
            p_load <= 1'b0;
        end
    end

    // shadow of what was sent, since the device words cannot be read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mir_mul <= MODE_RST;
            mir_alu <= MODE_RST;
        end else if (fire && LINK.req_load && LINK.req_unit) begin
            mir_alu[LINK.req_func[FB_NSEL +: NSEL_W]*NIB_W +: NIB_W]
                <= LINK.req_func[NIB_W-1:0];
        end else if (fire && LINK.req_load) begin
            mir_mul[LINK.req_func[FB_NSEL +: NSEL_W]*NIB_W +: NIB_W]
                <= LINK.req_func[NIB_W-1:0];
        end
    end

    // done is sticky; a new status in the clear cycle wins
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            done      <= 1'b0;
            last_stat <= STAT_NONE;
        end else if (LINK.stat_valid) begin
            done      <= 1'b1;
            last_stat <= LINK.stat;
        end else if (wr && PADDR == A_STATUS && PWDATA[SB_DONE]) begin
            done      <= 1'b0;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= '0;
        end else if (PSEL && !PENABLE) begin
            case (PADDR)
                A_STATUS: PRDATA <= {23'h0, done, last_stat, 3'h0, state != H_IDLE};
                A_MIRROR: PRDATA <= {mir_alu, mir_mul};
                default:  PRDATA <= '0;
            endcase
        end
    end
endmodule : fpmc_host_end

// *** testbench/fpmc_props.sv ***
// link timing and status checker for the pipeline control ends
`timescale 1ns/1ps
module fpmc_props (
    input wire logic                        CLK,        // system clock
    input wire logic                        RST_N,      // async reset, low
    input wire logic                        req,        // request
    input wire logic                        req_load,   // mode load
    input wire logic                        req_unit,   // 1 alu
    input wire logic                        req_dbl,    // double op
    input wire logic [fpmc_pkg::FUNC_W-1:0] req_func,   // function code
    input wire logic                        busy,       // op in flight
    input wire logic                        stat_valid, // status pulse
    input wire logic [fpmc_pkg::STAT_W-1:0] stat        // status
);
    import fpmc_pkg::*;
    logic [MODE_W-1:0] mw, aw, w;
    logic [5:0]        cnt, lat, nlat, p, a;
    wire               start = req && !req_load && !busy;
    // shadow words let the checker derive every latency itself
    always_comb begin
        w = req_unit ? aw : mw;
        p = {4'h0, w[9:8]} + 6'h01;
        a = {4'h0, w[7:6]} + 6'h01;
        nlat = p + p + 6'h01 + (req_unit ? p : (req_dbl || w[13]) ? a + a : a);
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            mw <= '0;
            aw <= '0;
        end else if (req && req_load && req_unit) begin
            aw[req_func[5:4]*4 +: 4] <= req_func[3:0];
        end else if (req && req_load) begin
            mw[req_func[5:4]*4 +: 4] <= req_func[3:0];
        end
    end
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cnt <= '0;
            lat <= '0;
        end else if (start) begin
            cnt <= 6'h01;
            lat <= nlat;
        end else if (stat_valid) begin
            cnt <= '0;
        end else if (cnt != 6'h00) begin
            cnt <= cnt + 6'h01;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    a_start_busy: assert property (start |=> busy)
        else $error("busy not raised after start");
    a_valid_on_time: assert property (cnt != 6'h00 && cnt == lat |-> stat_valid)
        else $error("status pulse missing at computed latency");
    a_valid_not_early: assert property (stat_valid |-> cnt == lat && cnt != 6'h00)
        else $error("status pulse off schedule");
    a_valid_single: assert property (stat_valid |=> !stat_valid)
        else $error("status pulse longer than one cycle");
    a_busy_span: assert property (busy |-> cnt != 6'h00 && cnt < lat)
        else $error("busy outside operation span");
    a_busy_ends: assert property ($fell(busy) |-> stat_valid)
        else $error("busy fell without status pulse");
    a_stat_hold: assert property ($changed(stat) |-> stat_valid)
        else $error("status changed without pulse");
    a_load_no_op: assert property (req && req_load && !busy |=> !busy)
        else $error("mode load started an operation");
endmodule : fpmc_props

// *** testbench/fpmc_tb_top.sv ***
// bench joining host and device ends over the link
`timescale 1ns/1ps
module fpmc_tb_top;
    import fpmc_pkg::*;
    logic        clk, rst_n, psel, pen, pwr, prdy, perr, fs, fz, fo, p1e, p34, hh, leg;
    logic        p2e, ree, dn, fr, ou, od;
    wire  [4:0]  sv;
    logic [7:0]  pa;
    logic [31:0] pwd, prd, r;
    logic [10:0] exc;
    logic [3:0]  cmp;
    logic [1:0]  cs, rm;
    int          fails, num_checks;
    int          sc[5];
    fpmc_link_if u_fpmc_link_if ();
    fpmc_host_end u_fpmc_host_end (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(pa), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
        .LINK(u_fpmc_link_if.host_mp));
    fpmc_dev_end u_fpmc_dev_end (.CLK(clk), .RST_N(rst_n), .LINK(u_fpmc_link_if.dev_mp),
        .EXC_IN(exc), .CMP_COND(cmp), .FIX_SIGN(fs), .FIX_ZERO(fz), .FIX_OVF(fo),
        .PIPE1_STB(sv[0]), .ACCUM_STB(sv[4]), .PIPE2_STB(sv[1]), .PIPE3_STB(sv[2]),
        .RESULT_STB(sv[3]), .PIPE1_EN(p1e), .PIPE2_EN(p2e), .PIPE34_EN(p34),
        .RESULT_EN(ree), .DENORM_FAST(dn), .ROUND_MODE(rm), .FIX_ROUND_ZERO(fr),
        .HI_HALF(hh), .LEGACY_COMMON(leg), .COMPAT_SEL(cs), .OP_UNIT(ou), .OP_DBL(od));
    fpmc_props u_fpmc_props (.CLK(clk), .RST_N(rst_n), .req(u_fpmc_link_if.req),
        .req_load(u_fpmc_link_if.req_load), .req_unit(u_fpmc_link_if.req_unit),
        .req_dbl(u_fpmc_link_if.req_dbl), .req_func(u_fpmc_link_if.req_func),
        .busy(u_fpmc_link_if.busy), .stat_valid(u_fpmc_link_if.stat_valid),
        .stat(u_fpmc_link_if.stat));
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    // strobe counts: pipe1, pipe2, pipe3, result, accumulate
    always @(posedge clk) begin
        for (int i = 0; i < 5; i++) begin
            if (sv[i] === 1'b1) sc[i]++;
        end
    end
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        num_checks++;
        if (s !== x) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, x, s);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic e);
        int n;
        logic ok;
        @(posedge clk);
        psel <= 1'b1; pwr <= w; pa <= a; pwd <= d;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        // answer read while settled, so the edge that takes it sees the same values
        do begin
            @(negedge clk);
            ok = prdy;
            r = prd;
            e = perr;
            @(posedge clk);
            n++;
        end while (ok !== 1'b1 && n < 50);
        if (n >= 50) begin fails++; conclude(); end
        psel <= 1'b0; pen <= 1'b0;
    endtask : apb
    // a host write is followed by a bounded poll until the host is idle again
    task automatic run(input logic [7:0] a, input logic [9:0] c);
        logic e;
        int n;
        apb(1'b1, A_STATUS, 32'h0000_0100, e);
        apb(1'b1, a, {22'h0, c}, e);
        n = 0;
        do begin apb(1'b0, A_STATUS, 32'h0, e); n++; end while (r[SB_PEND] !== 1'b0 && n < 40);
        if (n >= 40) begin fails++; conclude(); end
    endtask : run
    task automatic ld(input logic u, input logic [1:0] s, input logic [3:0] v);
        run(A_CMD, {1'b1, 1'b0, u, 1'b0, s, v});
    endtask : ld
    task automatic t_regs();
        logic e;
        logic [31:0] m[4];
        m = '{{16'h0, PRE_MUL_SLOW}, {16'h0, PRE_MUL_FAST}, {PRE_ALU_FAST, PRE_MUL_FAST},
              {PRE_ALU_SLOW, PRE_MUL_FAST}};
        apb(1'b0, A_MIRROR, 32'h0, e);
        chk("mirror reset", r, 32'h0);
        chk("legacy reset", leg, 1);
        apb(1'b0, 8'h10, 32'h0, e);
        chk("unmapped error", e, 1);
        for (int k = 0; k < 4; k++) begin
            run(A_PRESET, k[9:0]);
            apb(1'b0, A_MIRROR, 32'h0, e);
            chk("preset word", r, m[k]);
        end
        ld(1'b0, 2'h3, 4'h1);
        chk("legacy set", leg, 0);
        chk("compat field", cs, 2'h2);
    endtask : t_regs
    // every advance value on both units, both widths, mul select taken from the advance low bit
    task automatic t_timing();
        int sb[5];
        for (int u = 0; u < 2; u++) for (int n = 0; n < 4; n++) for (int d = 0; d < 2; d++) begin
            ld(u[0], 2'h2, {2'h0, n[1:0]});
            if (u == 0) ld(1'b0, 2'h1, {n[1:0], 2'h3});
            if (u == 0) ld(1'b0, 2'h3, {2'h0, n[0], 1'b0});
            sb = sc;
            run(A_CMD, {1'b0, d[0], u[0], 7'h00});
            chk("pipe1 strobes", sc[0] - sb[0], 2);
            chk("pipe2 strobes", sc[1] - sb[1], 1);
            chk("pipe3 strobes", sc[2] - sb[2], u == 0);
            chk("result strobes", sc[3] - sb[3], 1);
            chk("accum strobes", sc[4] - sb[4], u == 0);
            chk("op unit dbl", {ou, od}, {u[0], d[0]});
            chk("enables", {p1e, p2e, ree}, 3'h7);
            chk("upper half", hh, (u == 0 && d == 0));
            chk("pipes34 enable", p34, 0);
        end
        ld(1'b0, 2'h0, 4'h0);
        sb = sc;
        run(A_CMD, 10'h000);
        chk("pipe1 transparent", sc[0] - sb[0], 0);
        chk("pipe1 enable", p1e, 0);
    endtask : t_timing
    task automatic t_status();
        logic [9:0]  tc[6] = '{10'h0A0, 10'h0C1, 10'h0CD, 10'h0C0, 10'h000, 10'h090};
        logic [10:0] te[6] = '{11'h001, 11'h7FF, 11'h000, 11'h000, 11'h108, 11'h400};
        logic [2:0]  tf[6] = '{3'h0, 3'h7, 3'h2, 3'h0, 3'h0, 3'h0};
        logic [3:0]  tx[6] = '{4'hA, 4'hD, 4'h0, 4'h2, 4'h4, 4'hB};
        // alu low nibble all ones: fast mode, fix to zero, round mode 3
        ld(1'b1, 2'h0, 4'hF);
        for (int i = 0; i < 6; i++) begin
            exc <= te[i];
            {fs, fz, fo} <= tf[i];
            run(A_CMD, tc[i]);
            chk("status code", r[7:4], tx[i]);
            chk("done flag", r[SB_DONE], 1);
            chk("mode levels", {dn, fr, rm}, tc[i][7] ? 4'hF : 4'h0);
        end
    endtask : t_status
    initial begin
        rst_n = 1'b0; psel = 1'b0; pen = 1'b0; pwr = 1'b0; pa = '0; pwd = '0;
        exc = '0; cmp = 4'hA; fs = 1'b0; fz = 1'b0; fo = 1'b0;
        fails = 0; num_checks = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_timing();
        t_status();
        conclude();
    end
endmodule : fpmc_tb_top
